/* File: core/copro_branch_pkg.sv */
// Summary of operation
// RULE_01 - Target is slot address plus shifted sign-extended offset.
// RULE_02 - FP true-likely branches when selected bit is one.
// RULE_03 - Untaken likely branch nullifies its delay slot.
// RULE_04 - Omitted selector means condition bit zero.
// RULE_05 - Legacy forms share one sense/nullify operation.
// RULE_06 - FP condition bits written only by compares.
// RULE_07 - Old software keeps control transfers out of slots.
// RULE_08 - FP branch raises unusable, reserved, unimplemented.
// RULE_09 - Legacy selector addresses eight condition bits.
// RULE_10 - Zero/nonzero aux branches test the condition value.
// RULE_11 - Full five-bit condition field goes to coprocessor.
// RULE_12 - Newer aux branch: pc+4 target, slot always runs.
// RULE_13 - Newer mode: control transfer in slot is reserved.
// RULE_14 - Disabled coprocessor 2 raises coprocessor unusable.
// RULE_15 - Aux false branch taken on zero, slot runs.
// RULE_16 - Aux false-likely taken on zero, else nullify.
// RULE_17 - Likely forms predicted taken, tables left alone.
// RULE_18 - Newer mode keeps only zero/nonzero aux branches.
// RULE_19 - Software uses likely forms only when nearly certain.
// RULE_20 - Condition sampled at branch, PC changes after slot.
package copro_branch_pkg;
  // Instruction field positions.
  localparam int OP_HI      = 31;
  localparam int OP_LO      = 26;
  localparam int RS_HI      = 25;
  localparam int RS_LO      = 21;
  localparam int PICK_HI    = 20;
  localparam int PICK_LO    = 18;
  localparam int NULLIFY_BIT = 17;
  localparam int SENSE_BIT  = 16;
  localparam int FIELD6_HI  = 20;
  localparam int FIELD6_LO  = 16;
  localparam int OFF_HI     = 15;
  // Major opcodes and branch sub-codes.
  localparam logic [5:0] OP_COP1    = 6'h11;
  localparam logic [5:0] OP_COP2    = 6'h12;
  localparam logic [4:0] RS_BC      = 5'h08;
  localparam logic [4:0] RS_AUX_EQZ = 5'h09;
  localparam logic [4:0] RS_AUX_NEZ = 5'h0d;
  // Distance from a branch to its delay slot.
  localparam logic [31:0] SLOT_STEP = 32'h0000_0004;
  // Register byte offsets.
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_COUNT  = 4'h8;
  localparam logic [3:0] REG_TARGET = 4'hc;
  // Control register bits and reset value.
  localparam int CTRL_R6      = 0;
  localparam int CTRL_CP1EN   = 1;
  localparam int CTRL_CP2EN   = 2;
  localparam int CTRL_UNIMPL  = 3;
  localparam logic [3:0] CTRL_RESET = 4'h6;
  // Status register fields.
  localparam int ST_PEND  = 8;
  localparam int ST_TAKEN = 9;
  localparam int ST_NULL  = 10;
  // Branch sequencing states.
  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_SLOT = 2'b10
  } seq_t;
endpackage

/* File: core/fp_cond_bank.sv */
`timescale 1ns/1ps
`default_nettype none
// Holds the eight FP condition bits.
module fp_cond_bank (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cmpValid,
  input  wire logic [2:0] cmpIndex,
  input  wire logic       cmpResult,
  input  wire logic [2:0] readIndex,
  output logic      [7:0] condBits,
  output logic            selBit
);
  import copro_branch_pkg::*;

  // The whole state of the bank.
  typedef struct packed {
    logic [7:0] bits;
  } bank_t;

  bank_t s;   // Current state.
  bank_t n;   // Next state.

  // Only the compare port writes a bit; nothing else can. [RULE_06]
  always_comb begin
    n = s;
    if (cmpValid) begin
      n.bits[cmpIndex] = cmpResult;
    end
  end

  // Eight bits, so a three-bit index reaches all of them. [RULE_09]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Bypass is deliberately absent: a branch sees the bits as registered.
  assign condBits = s.bits;
  assign selBit   = s.bits[readIndex];
endmodule
`default_nettype wire

/* File: core/branch_decode.sv */
`timescale 1ns/1ps
`default_nettype none
// Recognises the coprocessor condition branches and forms the target.
module branch_decode (
  input  wire logic [31:0] instrWord,
  input  wire logic [31:0] instrPc,
  output logic             isFpBranch,
  output logic             isAuxLegacy,
  output logic             isAuxR6,
  output logic             sensePolarity,
  output logic             nullifySlotFlag,
  output logic       [2:0] condBitPick,
  output logic       [4:0] condFieldR6,
  output logic      [31:0] branchTarget
);
  import copro_branch_pkg::*;

  logic [5:0]  opField;   // Major opcode.
  logic [4:0]  rsField;   // Branch sub-code.
  logic [31:0] dispExt;   // Sign-extended, shifted displacement.

  // Plain field extraction and class decode.
  always_comb begin
    opField     = instrWord[OP_HI:OP_LO];
    rsField     = instrWord[RS_HI:RS_LO];
    isFpBranch  = (opField == OP_COP1) && (rsField == RS_BC);
    isAuxLegacy = (opField == OP_COP2) && (rsField == RS_BC);
    isAuxR6     = (opField == OP_COP2) &&
                  ((rsField == RS_AUX_EQZ) || (rsField == RS_AUX_NEZ));
    // The short assembler form encodes a zero here. [RULE_04]
    condBitPick = instrWord[PICK_HI:PICK_LO];
    // All five bits go to the coprocessor untouched. [RULE_11]
    condFieldR6 = instrWord[FIELD6_HI:FIELD6_LO];
    // One general operation steered by sense and nullify. [RULE_05]
    if (isAuxR6) begin
      sensePolarity   = (rsField == RS_AUX_NEZ);
      nullifySlotFlag = 1'b0;
    end else begin
      sensePolarity   = instrWord[SENSE_BIT];
      nullifySlotFlag = instrWord[NULLIFY_BIT];
    end
    // Offset shifted by two, sign extended, added to pc+4. [RULE_01]
    dispExt      = {{14{instrWord[OFF_HI]}}, instrWord[OFF_HI:0], 2'b00};
    branchTarget = instrPc + SLOT_STEP + dispExt;   // [RULE_12]
  end
endmodule
`default_nettype wire

/* File: core/copro_condition_branch_unit.sv */
`timescale 1ns/1ps
`default_nettype none
// Executes coprocessor condition branches, their delay slots and faults.
module copro_condition_branch_unit (
  input  wire logic        clk,
  input  wire logic        rst,
  // Avalon-MM slave for the control and status registers.
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Instruction stream from the pipeline, one per valid cycle.
  input  wire logic        instrValid,
  input  wire logic [31:0] instrWord,
  input  wire logic [31:0] instrPc,
  input  wire logic        instrIsCti,
  // Compare results that update the FP condition bits.
  input  wire logic        fpCmpValid,
  input  wire logic [2:0]  fpCmpIndex,
  input  wire logic        fpCmpResult,
  // Condition query towards coprocessor 2.
  output logic      [4:0]  auxCondSelect,
  input  wire logic        auxCondValue,
  // Results towards the PC logic.
  output logic             redirectValid,
  output logic      [31:0] redirectPc,
  output logic             slotNullify,
  output logic             excCopUnusable,
  output logic             excReserved,
  output logic             excUnimplemented,
  output logic             likelyPredict
);
  import copro_branch_pkg::*;

  // The whole state of the unit, except the FP condition bits held in u_bank, in one record.
  typedef struct packed {
    seq_t        seq;        // Waiting for a branch or for its slot.
    logic [3:0]  ctrl;       // Software control bits.
    logic        pendTaken;  // Outcome sampled at the branch.
    logic        pendLikely; // Branch is a likely form.
    logic [31:0] target;     // Target held across the slot.
    logic        redirect;   // One-cycle PC change pulse.
    logic        nullify;    // One-cycle slot cancel pulse.
    logic        excCu;      // Coprocessor unusable pulse.
    logic        excRi;      // Reserved instruction pulse.
    logic        excUi;      // Unimplemented operation pulse.
    logic        hint;       // Likely-branch prediction pulse.
    logic        lastTaken;  // Outcome of the last finished branch.
    logic        lastNull;   // Last slot was cancelled.
    logic [31:0] lastTarget; // Target of the last finished branch.
    logic [31:0] count;      // Number of taken branches.
    logic        ack;        // Bus answer cycle.
    logic [31:0] rdata;      // Captured read data.
  } state_t;

  state_t s;   // Current state.
  state_t n;   // Next state.

  logic        isFp;        // FP condition branch.
  logic        isAuxOld;    // Legacy coprocessor-2 branch.
  logic        isAuxNew;    // Zero/nonzero coprocessor-2 branch.
  logic        sense;       // Taken when condition equals this.
  logic        likely;      // Slot cancelled when not taken.
  logic [2:0]  pick;        // Legacy condition index.
  logic [4:0]  field6;      // Newer condition field.
  logic [31:0] target;      // Decoded branch target.
  logic [7:0]  fpBits;      // All FP condition bits.
  logic        fpSel;       // Selected FP condition bit.
  logic        isBranch;    // Any branch this unit handles.
  logic        acceptNow;   // Branch passes all fault checks.
  logic        condNow;     // Condition sampled this cycle.
  logic        slotNow;     // Delay slot instruction this cycle.
  logic        slotFault;   // Control transfer found in the slot in the newer mode.

  // Shared decoder for all forms.
  branch_decode u_decode (
    .instrWord       (instrWord),
    .instrPc         (instrPc),
    .isFpBranch      (isFp),
    .isAuxLegacy     (isAuxOld),
    .isAuxR6         (isAuxNew),
    .sensePolarity   (sense),
    .nullifySlotFlag (likely),
    .condBitPick     (pick),
    .condFieldR6     (field6),
    .branchTarget    (target)
  );

  // FP condition bit store, written by compares alone.
  fp_cond_bank u_bank (
    .clk       (clk),
    .rst       (rst),
    .cmpValid  (fpCmpValid),
    .cmpIndex  (fpCmpIndex),
    .cmpResult (fpCmpResult),
    .readIndex (pick),
    .condBits  (fpBits),
    .selBit    (fpSel)
  );

  // The coprocessor sees the full newer field, or the legacy index.
  always_comb begin
    if (isAuxNew) begin
      auxCondSelect = field6;   // [RULE_11]
    end else begin
      auxCondSelect = {2'b00, pick};
    end
  end

  // Fault checks and condition sampling for the branch in hand.
  always_comb begin
    isBranch  = isFp || isAuxOld || isAuxNew;
    slotNow   = instrValid && (s.seq == S_SLOT);
    // Pre-release-6 code keeps transfers out of slots; only the
    // newer mode checks, so older code is not slowed. [RULE_07]
    slotFault = slotNow && instrIsCti && s.ctrl[CTRL_R6];   // [RULE_13]
    acceptNow = 1'b0;
    if (instrValid && (s.seq == S_IDLE) && isBranch) begin
      if (isFp) begin
        acceptNow = !s.ctrl[CTRL_R6] && s.ctrl[CTRL_CP1EN] &&
                    !s.ctrl[CTRL_UNIMPL];
      end else if (isAuxOld) begin
        acceptNow = !s.ctrl[CTRL_R6] && s.ctrl[CTRL_CP2EN];
      end else begin
        acceptNow = s.ctrl[CTRL_R6] && s.ctrl[CTRL_CP2EN];
      end
    end
    if (isFp) begin
      condNow = fpSel;
    end else begin
      condNow = auxCondValue;
    end
  end

  // Next-state logic: bus slave, branch sequencing and fault pulses.
  always_comb begin
    n          = s;
    n.redirect = 1'b0;
    n.nullify  = 1'b0;
    n.excCu    = 1'b0;
    n.excRi    = 1'b0;
    n.excUi    = 1'b0;
    n.hint     = 1'b0;

    // Bus: first cycle captures read data, second cycle answers.
    // A write lands on the answer edge, when the master sees it.
    if ((read || write) && !s.ack) begin
      n.ack = 1'b1;
      case (address)
        REG_CTRL:   n.rdata = {28'h0, s.ctrl};
        REG_STATUS: n.rdata = {21'h0, s.lastNull, s.lastTaken,
                               s.seq == S_SLOT, fpBits};
        REG_COUNT:  n.rdata = s.count;
        REG_TARGET: n.rdata = s.lastTarget;
        default:    n.rdata = 32'h0;
      endcase
    end else begin
      n.ack = 1'b0;
    end
    if (write && s.ack && (address == REG_CTRL)) begin
      n.ctrl = writedata[3:0];
    end

    case (s.seq)
      S_IDLE: begin
        if (instrValid && isBranch) begin
          if (isFp) begin
            // FP form: removed in the newer mode, then enable, then
            // the optional unimplemented-operation trap. [RULE_08]
            if (s.ctrl[CTRL_R6]) begin
              n.excRi = 1'b1;   // [RULE_18]
            end else if (!s.ctrl[CTRL_CP1EN]) begin
              n.excCu = 1'b1;
            end else if (s.ctrl[CTRL_UNIMPL]) begin
              n.excUi = 1'b1;
            end
          end else if (isAuxOld) begin
            if (s.ctrl[CTRL_R6]) begin
              n.excRi = 1'b1;   // [RULE_18]
            end else if (!s.ctrl[CTRL_CP2EN]) begin
              n.excCu = 1'b1;   // [RULE_14]
            end
          end else begin
            // Newer forms exist only in the newer mode. [RULE_18]
            if (!s.ctrl[CTRL_R6]) begin
              n.excRi = 1'b1;
            end else if (!s.ctrl[CTRL_CP2EN]) begin
              n.excCu = 1'b1;   // [RULE_14]
            end
          end
          if (acceptNow) begin
            // Sample now, act after the slot. [RULE_20]
            // True forms take on one, false and zero forms on zero.
            n.pendTaken  = (condNow == sense);   // [RULE_02] [RULE_10]
            n.pendLikely = likely;               // [RULE_15] [RULE_16]
            n.target     = target;               // [RULE_01] [RULE_12]
            // Likely forms skip the predictor entirely. [RULE_17]
            n.hint       = likely;
            n.seq        = S_SLOT;
          end
        end
      end
      S_SLOT: begin
        if (instrValid) begin
          n.seq = S_IDLE;
          if (slotFault) begin
            // The slot faults; the branch does not complete. [RULE_13]
            n.excRi = 1'b1;
          end else begin
            // The slot has run; now steer the PC. [RULE_20]
            n.redirect   = s.pendTaken;
            // Untaken likely branch cancels its slot. [RULE_03]
            n.nullify    = s.pendLikely && !s.pendTaken;   // [RULE_16]
            n.lastTaken  = s.pendTaken;
            n.lastNull   = s.pendLikely && !s.pendTaken;
            n.lastTarget = s.target;
            if (s.pendTaken) begin
              n.count = s.count + 32'h1;
            end
          end
        end
      end
      default: begin
        n.seq = S_IDLE;
      end
    endcase
  end

  // State register; every field has a constant reset value.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s      <= '0;
      s.seq  <= S_IDLE;
      s.ctrl <= CTRL_RESET;
    end else begin
      s <= n;
    end
  end

  // Outputs other than waitrequest and auxCondSelect come straight from the state record.
  assign readdata         = s.rdata;
  assign waitrequest      = (read || write) && !s.ack;
  assign redirectValid    = s.redirect;
  assign redirectPc       = s.target;
  assign slotNullify      = s.nullify;
  assign excCopUnusable   = s.excCu;
  assign excReserved      = s.excRi;
  assign excUnimplemented = s.excUi;
  assign likelyPredict    = s.hint;

  // Reference target built independently of the decoder.
  logic [31:0] refTarget;
  assign refTarget = instrPc + 32'h4 +
                     {{14{instrWord[15]}}, instrWord[15:0], 2'b00};

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_target_formed: assert property ( // [RULE_01]
    acceptNow |=> (s.target == $past(refTarget)))
    else $error("Branch target not pc+4 plus shifted offset.");

  chk_fp_true_taken: assert property ( // [RULE_02]
    (acceptNow && isFp && sense && fpSel) |=> s.pendTaken)
    else $error("FP true branch not taken on set bit.");

  chk_likely_nullify: assert property ( // [RULE_03]
    (slotNow && !slotFault && s.pendLikely && !s.pendTaken)
    |=> (slotNullify && !redirectValid))
    else $error("Untaken likely branch did not cancel its slot.");

  chk_aux_zero_test: assert property ( // [RULE_10]
    (acceptNow && isAuxNew) |=> (s.pendTaken == ($past(auxCondValue)
                                 == $past(sense))))
    else $error("Zero/nonzero branch outcome wrong.");

  chk_slot_cti_fault: assert property ( // [RULE_13]
    slotFault |=> (excReserved && !redirectValid && !slotNullify))
    else $error("Transfer in slot not reported as reserved.");

  chk_aux_disabled: assert property ( // [RULE_14]
    (instrValid && s.seq == S_IDLE && (isAuxNew || isAuxOld) &&
     (isAuxNew == s.ctrl[CTRL_R6]) && !s.ctrl[CTRL_CP2EN])
    |=> (excCopUnusable && s.seq == S_IDLE))
    else $error("Disabled coprocessor 2 branch not refused.");

  chk_plain_slot_runs: assert property ( // [RULE_15]
    (slotNow && !slotFault && !s.pendLikely) |=> !slotNullify)
    else $error("Ordinary branch cancelled its slot.");

  chk_likely_hint: assert property ( // [RULE_17]
    likelyPredict |-> $past(acceptNow && likely))
    else $error("Prediction bypass without a likely branch.");

  chk_legacy_removed: assert property ( // [RULE_18]
    (instrValid && s.seq == S_IDLE && (isFp || isAuxOld) &&
     s.ctrl[CTRL_R6]) |=> (excReserved && s.seq == S_IDLE))
    else $error("Legacy branch accepted in newer mode.");

  chk_redirect_after: assert property ( // [RULE_20]
    redirectValid |-> ($past(slotNow) && $past(s.pendTaken)))
    else $error("PC changed without a finished delay slot.");

  chk_bus_answer: assert property (
    ((read || write) && waitrequest) |=> !waitrequest)
    else $error("Bus answer later than one wait cycle.");
endmodule
`default_nettype wire

/* File: verification/aux_cond_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Stand-in for coprocessor 2: a bank of 32 single-bit condition flags.
// It answers in the same cycle, as the real unit is required to.
module aux_cond_model (
  input  wire logic [4:0]  auxCondSelect, // Condition specifier from the core.
  input  wire logic [31:0] flags,         // Flag bank, loaded by the bench.
  output logic             auxCondValue   // Selected flag back to the core.
);
  // All five select bits pick a flag, so no specifier bit is ignored.
  assign auxCondValue = flags[auxCondSelect];
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the coprocessor condition branch unit.
module tb_top;
  import copro_branch_pkg::*;
  logic        clk, rst;            // Core clock and reset.
  logic [3:0]  address;             // Register bus address.
  logic        read, write;         // Register bus strobes.
  logic [31:0] writedata, readdata; // Register bus data.
  logic        waitrequest;         // Register bus stall.
  logic        instrValid, instrIsCti; // Instruction stream qualifiers.
  logic [31:0] instrWord, instrPc;  // Instruction and its address.
  logic        fpCmpValid, fpCmpResult; // FP compare write port.
  logic [2:0]  fpCmpIndex;          // FP compare target bit.
  logic [4:0]  auxCondSelect;       // Query towards coprocessor 2.
  logic        auxCondValue;        // Answer from coprocessor 2.
  logic        redirectValid, slotNullify, likelyPredict; // PC results.
  logic [31:0] redirectPc;          // Redirect target.
  logic        excCopUnusable, excReserved, excUnimplemented; // Faults.
  logic [31:0] flags;               // Coprocessor 2 flag bank.
  logic [7:0]  fpBits;              // Expected FP condition bits.
  logic [3:0]  ctrl;                // Expected control register.
  logic [31:0] lastTgt, rd, rnd;    // Scratch for expectations.
  logic [1:0]  lastOut;             // Expected last nullify and taken.
  int          failures, totalChecks, seed, takenCount;

  copro_condition_branch_unit u_dut (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .instrValid(instrValid), .instrWord(instrWord), .instrPc(instrPc),
    .instrIsCti(instrIsCti), .fpCmpValid(fpCmpValid),
    .fpCmpIndex(fpCmpIndex), .fpCmpResult(fpCmpResult),
    .auxCondSelect(auxCondSelect), .auxCondValue(auxCondValue),
    .redirectValid(redirectValid), .redirectPc(redirectPc),
    .slotNullify(slotNullify), .excCopUnusable(excCopUnusable),
    .excReserved(excReserved), .excUnimplemented(excUnimplemented),
    .likelyPredict(likelyPredict));

  aux_cond_model u_cop2 (
    .auxCondSelect(auxCondSelect), .flags(flags),
    .auxCondValue(auxCondValue));

  // Free-running 250 MHz core clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Compares one value and counts it; a mismatch is reported at once.
  task automatic check(input logic [31:0] seen, exp, input string msg);
    totalChecks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s seen %h expected %h",
               $time, msg, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Bus cycle: the request stands until waitrequest is seen low.
  task automatic bus_xfer(input logic wr, input logic [3:0] a,
                          input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    // No wait count is assumed; only the watchdog ends a stuck wait.
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // One FP compare result written into a condition bit.
  task automatic fp_cmp(input logic [2:0] idx, input logic res);
    @(posedge clk);
    fpCmpValid <= 1'b1;
    fpCmpIndex <= idx;
    fpCmpResult <= res;
    @(posedge clk);
    fpCmpValid <= 1'b0;
    fpBits[idx] = res;
  endtask

  // Issues a branch, then its slot unless the branch faults, and checks every result pulse.
  task automatic run_branch(input logic [31:0] w, pc,
                            input logic cti, flip);
    logic       fp, aLeg, aR6, cond, likely, res, unus, unimp, fault, r6;
    logic [4:0] sel;
    logic       go;
    logic [31:0] tgt;
    @(posedge clk);
    // Expectations use the condition state as it stands at issue.
    r6 = ctrl[CTRL_R6];
    fp = w[OP_HI:OP_LO] == OP_COP1 && w[RS_HI:RS_LO] == RS_BC;
    aLeg = w[OP_HI:OP_LO] == OP_COP2 && w[RS_HI:RS_LO] == RS_BC;
    aR6 = !fp && !aLeg;
    sel = aR6 ? w[FIELD6_HI:FIELD6_LO] : {2'b00, w[PICK_HI:PICK_LO]};
    if (fp) cond = fpBits[w[PICK_HI:PICK_LO]] == w[SENSE_BIT];
    else if (aLeg) cond = flags[sel] == w[SENSE_BIT];
    else cond = flags[sel] == (w[RS_HI:RS_LO] == RS_AUX_NEZ);
    likely = !aR6 && w[NULLIFY_BIT];
    res = r6 ? !aR6 : aR6;
    unus = !res && !(fp ? ctrl[CTRL_CP1EN] : ctrl[CTRL_CP2EN]);
    unimp = !res && !unus && fp && ctrl[CTRL_UNIMPL];
    fault = res | unus | unimp;
    tgt = pc + SLOT_STEP + {{14{w[15]}}, w[15:0], 2'b00};
    instrValid <= 1'b1;
    instrWord <= w;
    instrPc <= pc;
    instrIsCti <= 1'b0;
    @(posedge clk);
    check({27'h0, auxCondSelect}, {27'h0, sel}, "select");
    instrValid <= 1'b0;
    // Changing the condition after issue must not alter the outcome.
    if (flip) flags <= ~flags;
    @(posedge clk);
    check({31'h0, excReserved}, {31'h0, res}, "reserved");
    check({31'h0, excCopUnusable}, {31'h0, unus}, "unusable");
    check({31'h0, excUnimplemented}, {31'h0, unimp}, "unimpl");
    check({31'h0, likelyPredict}, {31'h0, !fault && likely}, "pred");
    if (!fault) begin
      instrValid <= 1'b1;
      instrWord <= 32'h0000_0000;
      instrPc <= pc + SLOT_STEP;
      instrIsCti <= cti;
      @(posedge clk);
      instrValid <= 1'b0;
      @(posedge clk);
      go = cond && !(r6 && cti);
      check({31'h0, excReserved}, {31'h0, r6 && cti}, "slot cti");
      check({31'h0, redirectValid}, {31'h0, go}, "taken");
      check({31'h0, slotNullify}, {31'h0, likely && !cond && !(r6 && cti)},
            "nullify");
      if (go) begin
        check(redirectPc, tgt, "target");
        takenCount++;
      end
      // Every branch whose slot completes updates the last-branch record.
      if (!(r6 && cti)) begin
        lastTgt = tgt;
        lastOut = {likely && !cond, cond};
      end
    end
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    give_verdict();
  end

  // Main sequence: reset, registers, corner branches, random branches.
  initial begin
    seed = 23;
    {rst, read, write, instrValid, instrIsCti, fpCmpValid} = 6'h20;
    {address, writedata, instrWord, instrPc} = '0;
    {fpCmpIndex, fpCmpResult, fpBits, takenCount} = '0;
    {lastTgt, lastOut} = '0;
    flags = 32'h0000_0000;
    ctrl = CTRL_RESET;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    bus_xfer(1'b0, REG_CTRL, '0, rd);
    check(rd, {28'h0, CTRL_RESET}, "ctrl reset");
    bus_xfer(1'b0, 4'h2, '0, rd);
    check(rd, 32'h0, "unmapped");
    bus_xfer(1'b1, REG_STATUS, 32'h0000_00ff, rd);
    for (int i = 0; i < 8; i++) begin
      rnd = $random(seed);
      fp_cmp(i[2:0], rnd[0] | (i == 7));
    end
    fp_cmp(3'h0, 1'b0);
    bus_xfer(1'b0, REG_STATUS, '0, rd);
    check({24'h0, rd[7:0]}, {24'h0, fpBits}, "fp bits");
    $display("test registers done");
    // True-likely on bit 7 with the most negative offset, then bit 0.
    run_branch({OP_COP1, RS_BC, 3'h7, 2'b11, 16'h8000}, 32'h0010_0000,
               1'b0, 1'b0);
    run_branch({OP_COP1, RS_BC, 3'h0, 2'b11, 16'h7fff}, 32'h0000_4000,
               1'b0, 1'b0);
    run_branch({OP_COP2, RS_BC, 3'h1, 2'b10, 16'h0010}, 32'h0000_0100,
               1'b0, 1'b1);
    $display("test corner branches done");
    for (int i = 0; i < 80; i++) begin
      rnd = $random(seed);
      ctrl = {rnd[3] & rnd[4], rnd[2] | rnd[5], rnd[1] | rnd[6], rnd[0]};
      bus_xfer(1'b1, REG_CTRL, {28'h0, ctrl}, rd);
      flags <= $random(seed);
      rnd = $random(seed);
      case (rnd[23:22])
        2'd0: rnd[31:21] = {OP_COP1, RS_BC};
        2'd1: rnd[31:21] = {OP_COP2, RS_BC};
        2'd2: rnd[31:21] = {OP_COP2, RS_AUX_EQZ};
        default: rnd[31:21] = {OP_COP2, RS_AUX_NEZ};
      endcase
      // Bits 31:21 now hold the opcode, so slot and flip come fresh.
      rd = $random(seed);
      // Only newer-mode code puts a transfer in a slot.
      run_branch(rnd, {$random(seed)} & 32'hffff_fffc,
                 rd[0] & ctrl[CTRL_R6], rd[1]);
    end
    bus_xfer(1'b0, REG_COUNT, '0, rd);
    check(rd, takenCount, "count");
    bus_xfer(1'b0, REG_TARGET, '0, rd);
    check(rd, lastTgt, "last target");
    bus_xfer(1'b0, REG_STATUS, '0, rd);
    check({24'h0, rd[7:0]}, {24'h0, fpBits}, "fp bits kept");
    check({29'h0, rd[10:8]}, {29'h0, lastOut, 1'b0}, "last out");
    $display("test random branches done");
    give_verdict();
  end
endmodule
`default_nettype wire
